// [common/sdpci_pkg.sv]
// Purpose: Shared constants and types for the SDRAM pin command link.
// Assumes: Both ends run on one 20 MHz clock.
// Notes:   Command codes are {cs_n, ras_n, cas_n, we_n}.
package sdpci_pkg;

  // ---------------------------------------------------------------
  // Pin widths
  // ---------------------------------------------------------------
  localparam int BANK_W = 2;  // Four banks
  localparam int ADDR_W = 12; // Row address width
  localparam int COL_W  = 8;  // Column address width
  localparam int DQ_W   = 32; // Data bus
  localparam int LANES  = 4;  // Byte lanes
  localparam int LANE_W = 8;  // Bits per lane
  localparam int AP_BIT = 10; // Auto precharge / all banks

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_LOAD  = 4'h0;
  localparam logic [3:0] CODE_RFSH  = 4'h1;
  localparam logic [3:0] CODE_PRE   = 4'h2;
  localparam logic [3:0] CODE_ACT   = 4'h3;
  localparam logic [3:0] CODE_WRITE = 4'h4;
  localparam logic [3:0] CODE_READ  = 4'h5;
  localparam logic [3:0] CODE_TERM  = 4'h6;
  localparam logic [3:0] CODE_NOP   = 4'h7;
  localparam logic [3:0] CODE_DESEL = 4'hF;

  // ---------------------------------------------------------------
  // Mode word fields and timing
  // ---------------------------------------------------------------
  localparam int         BL_LSB   = 0;      // Burst length code
  localparam int         CL_LSB   = 4;      // Read latency code
  localparam logic [2:0] BL_1     = 3'h0;
  localparam logic [2:0] BL_2     = 3'h1;
  localparam logic [2:0] BL_4     = 3'h2;
  localparam logic [2:0] BL_8     = 3'h3;
  localparam logic [2:0] BL_FULL  = 3'h7;
  localparam logic [2:0] CL_1     = 3'h1;
  localparam logic [2:0] CL_2     = 3'h2;
  localparam logic [7:0] PAGE_MSK = 8'hFF;  // Full page wrap
  localparam int         MASK_LAT = 2;      // Read mask latency, clocks
  localparam logic [11:0] MODE_RST = 12'h000;

  // Power state of the memory end
  typedef enum logic [2:0] {
    PWR_RUN, PWR_SUSPEND, PWR_ACT_PD, PWR_PRE_PD, PWR_SELF
  } sdpci_pwr_t;

  // Controller user commands
  typedef enum logic [3:0] {
    UC_NOP, UC_DESEL, UC_ACT, UC_READ, UC_WRITE,
    UC_PRE, UC_RFSH, UC_LOAD, UC_TERM
  } sdpci_cmd_t;

endpackage : sdpci_pkg

// [common/sdpci_if.sv]
// Purpose: Pin bundle between memory controller and memory.
// Assumes: Shared clock supplied to both ends by the bench.
// Notes:   Data wire resolved per lane from the enables; idle lanes read 0.
`timescale 1ns/100ps
interface sdpci_if;

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  logic                          cke;        // Clock enable
  logic                          cs_n;       // Chip select
  logic                          ras_n;      // Row strobe
  logic                          cas_n;      // Column strobe
  logic                          we_n;       // Write strobe
  logic [sdpci_pkg::BANK_W-1:0]  ba;         // Bank select
  logic [sdpci_pkg::ADDR_W-1:0]  addr;       // Address
  logic [sdpci_pkg::LANES-1:0]   dqm;        // Byte masks
  logic [sdpci_pkg::DQ_W-1:0]    host_dq;    // Controller drive
  logic                          host_dq_oe; // Controller enable
  logic [sdpci_pkg::DQ_W-1:0]    dev_dq;     // Memory drive
  logic [sdpci_pkg::LANES-1:0]   dev_dq_oe;  // Memory lane enables
  logic [sdpci_pkg::DQ_W-1:0]    dq;         // Resolved data wire

  // Wire level per lane; controller wins a clash
  always_comb begin
    for (int k = 0; k < sdpci_pkg::LANES; k++) begin
      if (host_dq_oe) begin
        dq[k*8 +: 8] = host_dq[k*8 +: 8];
      end else if (dev_dq_oe[k]) begin
        dq[k*8 +: 8] = dev_dq[k*8 +: 8];
      end else begin
        dq[k*8 +: 8] = 8'h00;
      end
    end
  end

  modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
                output dev_dq, dev_dq_oe);
  modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
                output host_dq, host_dq_oe, input dq);

endinterface : sdpci_if

// [hdl/sdpci_device.sv]
// Purpose: Memory end of the pin link: decode, banks, bursts, masks.
// Assumes: Pins change only between rising edges of sys_clk_in.
// Notes:   Only a small window of the array is stored in flops.
//
// Functional notes
// - Sample all pins on rising clock only
// - Each clock steps burst column and outputs
// - Clock enable low picks suspend or power-down
// - Clock enable asynchronous while powered down
// - Ignore all inputs but clock enable while powered down
// - Controller may hold clock enable high
// - Chip select high masks every command
// - Bursts and masks continue under chip deselect
// - Command from four strobes same edge
// - Write mask high blocks byte write
// - Read mask high floats lane two clocks later
// - Mask bit n covers byte lane n
// - Bank select picks bank for commands
// - Column from low address, auto precharge bit
// - Precharge all when auto precharge bit high
// - Load mode takes address as opcode
// - Activate opens row from twelve bits
// - Shared 32-bit two-way data bus
`timescale 1ns/100ps
module sdpci_device #(
  parameter int ROW_KEEP = 1, // Row bits kept in storage
  parameter int COL_KEEP = 3  // Column bits kept in storage
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  sdpci_if.dev            pins,
  output logic [2:0]      pwr_state_out,
  output logic            burst_active_out
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (ROW_KEEP < 1 || ROW_KEEP > 12 || COL_KEEP < 1 || COL_KEEP > 8) begin : g_chk
    $error("sdpci_device: storage window out of range");
  end

  localparam int IDX_W = 2 + ROW_KEEP + COL_KEEP; // Storage index
  localparam int DEPTH = 1 << IDX_W;              // Stored words

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sdpci_pkg::sdpci_pwr_t    pwr;   // Power state
    logic [11:0]              mode;  // Mode word
    logic [3:0]               open;  // Bank has open row
    logic [3:0][11:0]         row;   // Open row per bank
    logic                     busy;  // Burst running
    logic                     wr;    // Burst is a write
    logic                     ap;    // Close bank at end
    logic                     full;  // Full page burst
    logic [1:0]               bank;  // Burst bank
    logic [7:0]               col0;  // Start column
    logic [7:0]               beat;  // Beats done
    logic [3:0]               left;  // Beats still due
    logic [1:0]               rv;    // Read pipe valid
    logic [1:0][31:0]         rd;    // Read pipe data
    logic [31:0]              dq;    // Output data
    logic [3:0]               oe;    // Output lane enables
    logic [3:0]               m1;    // Mask, one clock old
    logic [3:0]               m2;    // Mask, two clocks old
    logic                     ck1;   // Enable sync, first
    logic                     ck2;   // Enable sync, second
    logic [DEPTH-1:0][31:0]   mem;   // Stored words
  } sdpci_dstate_t;

  sdpci_dstate_t q;  // Registered state
  sdpci_dstate_t n;  // Next state

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0]       cmd;    // Strobe code
    logic             clk_on; // Internal clock running
    logic             cs_on;  // Decoder enabled
    logic             go;     // New burst this edge
    logic             step;   // A beat this edge
    logic             s_wr;   // Beat direction
    logic [1:0]       s_bank; // Beat bank
    logic [7:0]       s_col0; // Beat start column
    logic [7:0]       s_beat; // Beat number
    logic [7:0]       msk;    // Burst wrap mask
    logic [7:0]       col;    // Beat column
    logic [IDX_W-1:0] idx;    // Storage index
    logic             rdv;    // Read beat made
    logic [31:0]      rdw;    // Read beat word
    logic             selv;   // Word due on bus
    logic [31:0]      seld;   // Word due data
    n      = q;
    cmd    = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    cs_on  = !pins.cs_n;
    clk_on = (q.pwr == sdpci_pkg::PWR_RUN) && pins.cke;
    go     = 1'b0;
    step   = 1'b0;
    s_wr   = q.wr;
    s_bank = q.bank;
    s_col0 = q.col0;
    s_beat = q.beat;
    msk    = 8'h00;
    col    = 8'h00;
    idx    = '0;
    rdv    = 1'b0;
    rdw    = 32'h0000_0000;
    selv   = 1'b0;
    seld   = 32'h0000_0000;

    // Burst wrap from mode word
    unique case (q.mode[sdpci_pkg::BL_LSB +: 3])
      sdpci_pkg::BL_2:    msk = 8'h01;
      sdpci_pkg::BL_4:    msk = 8'h03;
      sdpci_pkg::BL_8:    msk = 8'h07;
      sdpci_pkg::BL_FULL: msk = sdpci_pkg::PAGE_MSK;
      default:            msk = 8'h00; // BL_1 and reserved codes
    endcase

    // Enable synchroniser runs every edge but power-down entry; first flop feeds only the second
    n.ck1 = pins.cke;
    n.ck2 = q.ck1;

    // Power state transitions
    unique case (q.pwr)
      sdpci_pkg::PWR_RUN: begin
        if (!pins.cke) begin
          if (q.busy) begin
            n.pwr = sdpci_pkg::PWR_SUSPEND;          // Burst frozen
          end else begin
            // Leaving synchronous sampling; sync restarts from low
            n.ck1 = 1'b0;
            n.ck2 = 1'b0;
            n.rv  = 2'b00;
            n.oe  = 4'h0;                            // Release the bus
            if (cs_on && cmd == sdpci_pkg::CODE_RFSH) begin
              n.pwr = sdpci_pkg::PWR_SELF;
            end else if (|q.open) begin
              n.pwr = sdpci_pkg::PWR_ACT_PD;
            end else begin
              n.pwr = sdpci_pkg::PWR_PRE_PD;
            end
          end
        end
      end
      sdpci_pkg::PWR_SUSPEND: begin
        if (pins.cke) begin                          // Synchronous exit
          n.pwr = sdpci_pkg::PWR_RUN;
        end
      end
      sdpci_pkg::PWR_ACT_PD, sdpci_pkg::PWR_PRE_PD, sdpci_pkg::PWR_SELF: begin
        // Only the synchronised enable is looked at here
        if (q.ck2) begin
          n.pwr = sdpci_pkg::PWR_RUN;
        end
      end
      default: n.pwr = sdpci_pkg::PWR_RUN;           // Unused codes
    endcase

    // Commands, only with the clock running and chip selected
    if (clk_on && cs_on) begin
      unique case (cmd)
        sdpci_pkg::CODE_ACT: begin
          n.open[pins.ba] = 1'b1;
          n.row[pins.ba]  = pins.addr;
        end
        sdpci_pkg::CODE_PRE: begin
          if (pins.addr[sdpci_pkg::AP_BIT]) begin
            n.open = 4'h0;
          end else begin
            n.open[pins.ba] = 1'b0;
          end
        end
        sdpci_pkg::CODE_LOAD: n.mode = pins.addr;
        sdpci_pkg::CODE_READ, sdpci_pkg::CODE_WRITE: begin
          go     = 1'b1;
          s_wr   = (cmd == sdpci_pkg::CODE_WRITE);
          s_bank = pins.ba;
          s_col0 = pins.addr[sdpci_pkg::COL_W-1:0];
          s_beat = 8'h00;
          n.ap   = pins.addr[sdpci_pkg::AP_BIT];
          n.full = (q.mode[sdpci_pkg::BL_LSB +: 3] == sdpci_pkg::BL_FULL);
        end
        sdpci_pkg::CODE_TERM: begin
          n.busy = 1'b0;
          n.full = 1'b0;
        end
        default: ;                                   // Refresh, no-op
      endcase
    end

    // Burst beat; runs on under chip deselect
    step = clk_on && (go || (q.busy && !(cs_on && cmd == sdpci_pkg::CODE_TERM)));
    if (step) begin
      col = (s_col0 & ~msk) | ((s_col0 + s_beat) & msk);
      idx = {s_bank, q.row[s_bank][ROW_KEEP-1:0], col[COL_KEEP-1:0]};
      if (s_wr) begin
        for (int k = 0; k < sdpci_pkg::LANES; k++) begin
          if (!pins.dqm[k]) begin
            n.mem[idx][k*8 +: 8] = pins.dq[k*8 +: 8];
          end
        end
      end else begin
        rdv = 1'b1;
        rdw = q.mem[idx];
      end
      n.wr   = s_wr;
      n.bank = s_bank;
      n.col0 = s_col0;
      n.beat = s_beat + 8'h01;
      n.left = go ? msk[3:0] : (q.left - 4'h1);
      n.busy = n.full || (n.left != 4'h0);
      if (!n.busy && n.ap) begin
        n.open[s_bank] = 1'b0;                       // Auto precharge
      end
    end

    // Output pipeline and mask delay, frozen while suspended
    if (clk_on) begin
      unique case (q.mode[sdpci_pkg::CL_LSB +: 3])
        sdpci_pkg::CL_1: begin
          selv = rdv;
          seld = rdw;
        end
        sdpci_pkg::CL_2: begin
          selv = q.rv[0];
          seld = q.rd[0];
        end
        default: begin                               // Three and reserved
          selv = q.rv[1];
          seld = q.rd[1];
        end
      endcase
      n.rv = {q.rv[0], rdv};
      n.rd = {q.rd[0], rdw};
      n.m1 = pins.dqm;
      n.m2 = q.m1;
      n.dq = seld;
      n.oe = {sdpci_pkg::LANES{selv}} & ~q.m2;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Whole state in one flop bank; reset to all zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pins.dev_dq       = q.dq;
  assign pins.dev_dq_oe    = q.oe;
  assign pwr_state_out     = q.pwr;
  assign burst_active_out  = q.busy;

endmodule : sdpci_device

// [hdl/sdpci_host.sv]
// Purpose: Controller end: turns user commands into registered pins.
// Assumes: User keeps clock enable high during reads it wants back.
// Notes:   Read capture follows the latency in the last mode it sent.
`timescale 1ns/100ps
module sdpci_host (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_b_in,
  sdpci_if.host                      pins,
  input  wire logic                  user_cmd_valid_in,
  input  wire sdpci_pkg::sdpci_cmd_t user_cmd_in,
  input  wire logic [1:0]            user_bank_in,
  input  wire logic [11:0]           user_addr_in,
  input  wire logic [3:0]            user_mask_in,
  input  wire logic                  user_wdata_valid_in,
  input  wire logic [31:0]           user_wdata_in,
  input  wire logic                  user_cke_in,
  output logic [31:0]                user_rdata_out,
  output logic                       user_rdata_valid_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        cke;    // Clock enable pin
    logic [3:0]  code;   // Strobe pins
    logic [1:0]  ba;     // Bank pins
    logic [11:0] addr;   // Address pins
    logic [3:0]  dqm;    // Mask pins
    logic [31:0] dq;     // Data drive
    logic        dq_oe;  // Data enable
    logic [11:0] mode;   // Copy of mode sent
    logic        rbusy;  // Read beats still owed
    logic        rfull;  // Full page read
    logic [3:0]  rleft;  // Beats owed
    logic [3:0]  sl;     // Expected data line
    logic [31:0] rdata;  // Captured word
    logic        rvalid; // Captured word valid
  } sdpci_hstate_t;

  sdpci_hstate_t q;  // Registered state
  sdpci_hstate_t n;  // Next state

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] code; // Strobes for this command
    logic [3:0] bl_m; // Burst length less one
    logic       push; // Device makes a read beat next edge
    n    = q;
    push = 1'b0;
    code = sdpci_pkg::CODE_NOP;
    bl_m = 4'h0;
    unique case (user_cmd_valid_in ? user_cmd_in : sdpci_pkg::UC_NOP)
      sdpci_pkg::UC_ACT:   code = sdpci_pkg::CODE_ACT;
      sdpci_pkg::UC_READ:  code = sdpci_pkg::CODE_READ;
      sdpci_pkg::UC_WRITE: code = sdpci_pkg::CODE_WRITE;
      sdpci_pkg::UC_PRE:   code = sdpci_pkg::CODE_PRE;
      sdpci_pkg::UC_RFSH:  code = sdpci_pkg::CODE_RFSH;
      sdpci_pkg::UC_LOAD:  code = sdpci_pkg::CODE_LOAD;
      sdpci_pkg::UC_TERM:  code = sdpci_pkg::CODE_TERM;
      sdpci_pkg::UC_DESEL: code = sdpci_pkg::CODE_DESEL;
      default:             code = sdpci_pkg::CODE_NOP;
    endcase
    unique case (q.mode[sdpci_pkg::BL_LSB +: 3])
      sdpci_pkg::BL_2: bl_m = 4'h1;
      sdpci_pkg::BL_4: bl_m = 4'h3;
      sdpci_pkg::BL_8: bl_m = 4'h7;
      default:         bl_m = 4'h0;
    endcase

    // Pins registered; holding user_cke_in high is allowed
    n.cke   = user_cke_in;
    n.code  = code;
    n.ba    = user_bank_in;
    n.addr  = user_addr_in;
    n.dqm   = user_mask_in;
    n.dq    = user_wdata_in;
    n.dq_oe = user_wdata_valid_in;

    // Track the read beats owed by the device
    if (q.rbusy) begin
      push    = 1'b1;
      n.rleft = q.rleft - 4'h1;
      n.rbusy = q.rfull || (q.rleft != 4'h1);
    end
    unique case (code)
      sdpci_pkg::CODE_LOAD: n.mode = user_addr_in;
      sdpci_pkg::CODE_READ: begin
        push    = 1'b1;
        n.rfull = (q.mode[sdpci_pkg::BL_LSB +: 3] == sdpci_pkg::BL_FULL);
        n.rleft = bl_m;
        n.rbusy = n.rfull || (bl_m != 4'h0);
      end
      sdpci_pkg::CODE_WRITE, sdpci_pkg::CODE_TERM: begin
        push    = 1'b0;                              // Read cut short
        n.rbusy = 1'b0;
        n.rfull = 1'b0;
      end
      default: ;
    endcase

    // Capture one edge after the word is on the wire
    n.sl    = {q.sl[2:0], push};
    n.rdata = pins.dq;
    unique case (q.mode[sdpci_pkg::CL_LSB +: 3])
      sdpci_pkg::CL_1: n.rvalid = q.sl[1];
      sdpci_pkg::CL_2: n.rvalid = q.sl[2];
      default:         n.rvalid = q.sl[3];
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset: deselected, clock enable high, bus released
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q       <= '0;
      q.cke   <= 1'b1;
      q.code  <= sdpci_pkg::CODE_DESEL;
      q.mode  <= sdpci_pkg::MODE_RST;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pins.cke             = q.cke;
  assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = q.code;
  assign pins.ba              = q.ba;
  assign pins.addr            = q.addr;
  assign pins.dqm             = q.dqm;
  assign pins.host_dq         = q.dq;
  assign pins.host_dq_oe      = q.dq_oe;
  assign user_rdata_out       = q.rdata;
  assign user_rdata_valid_out = q.rvalid;

endmodule : sdpci_host

// [tb/sdpci_link_monitor.sv]
// Purpose: Watches the pin link between controller and memory.
// Assumes: Mode word 12'h022 (burst 4, latency 2) goes out first.
// Notes:   Takes the interface signals as plain inputs.
`timescale 1ns/100ps
module sdpci_link_monitor (
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [3:0]  dqm,
  input wire logic        host_dq_oe,
  input wire logic [31:0] dev_dq,
  input wire logic [3:0]  dev_dq_oe,
  input wire logic [31:0] dq
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic        rd_w;     // Read code seen with clock enabled
  logic [3:0]  rd_age_q; // Edges since last read
  logic [31:0] lane_w;   // Driven lanes as bit mask
  assign rd_w   = cke && ({cs_n, ras_n, cas_n, we_n} == sdpci_pkg::CODE_READ);
  assign lane_w = {{8{dev_dq_oe[3]}}, {8{dev_dq_oe[2]}}, {8{dev_dq_oe[1]}}, {8{dev_dq_oe[0]}}};
  // Age stops while clock is gated, so a suspended burst is not cut short
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_age_q <= 4'hF;
    end else if (rd_w) begin
      rd_age_q <= 4'h0;
    end else if (cke && rd_age_q != 4'hF) begin
      rd_age_q <= rd_age_q + 4'h1;
    end
  end
  sequence rd_clean_s;
    rd_w && dqm == 4'h0 && $past(dqm) == 4'h0 ##1 cke;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_pins_idle: assert property (
    $rose(rst_b_in) |-> cke && cs_n && !host_dq_oe) else $error("pins busy after reset");
  a_mask_floats_lane: assert property (
    $past(cke) && $past(cke, 2) && $past(cke, 3) && $past(cke, 4) |-> (dev_dq_oe & $past(dqm, 3)) == 4'h0)
    else $error("masked lane driven");
  a_read_lanes_drive: assert property (
    rd_clean_s |-> ##1 dev_dq_oe == 4'hF) else $error("read beat missing");
  a_idle_no_drive: assert property (
    rd_age_q > 4'h7 |-> dev_dq_oe == 4'h0) else $error("drive without read");
  a_suspend_holds_out: assert property (
    !cke && !$past(cke) && !$past(cke, 2) |-> $stable(dev_dq_oe) && $stable(dev_dq))
    else $error("outputs moved while gated");
  a_bus_no_clash: assert property (
    host_dq_oe |-> dev_dq_oe == 4'h0) else $error("both ends drive");
  a_write_drives_bus: assert property (
    cke && {cs_n, ras_n, cas_n, we_n} == sdpci_pkg::CODE_WRITE |-> host_dq_oe) else $error("write data absent");
  a_lane_resolves: assert property (
    !host_dq_oe |-> dq == (dev_dq & lane_w)) else $error("wire level wrong");
  c_clean_read: cover property (rd_clean_s);
  c_gated_run: cover property (!cke ##1 !cke ##1 !cke);
  c_part_lanes: cover property (dev_dq_oe != 4'h0 && dev_dq_oe != 4'hF);
endmodule : sdpci_link_monitor

// [tb/sdram_pin_command_interface_tb.sv]
// Purpose: Self-checking bench for controller and memory ends.
// Assumes: Mode 12'h022 gives burst 4 and read latency 2.
// Notes:   Model keeps the stored window only; row fixed per bank.
`timescale 1ns/100ps
module sdram_pin_command_interface_tb;
  logic                  sys_clk_in = 1'b0; // 20 MHz clock
  logic                  rst_b_in   = 1'b0; // Reset, active low
  sdpci_pkg::sdpci_cmd_t cmd = sdpci_pkg::UC_DESEL;
  logic [1:0]            bk = 2'h0;
  logic [11:0]           ad = 12'h000;
  logic [3:0]            mk = 4'h0;
  logic                  wv = 1'b0;
  logic                  cv = 1'b1;        // Command valid; low sends no-op
  logic [31:0]           wd = 32'h0;
  logic                  cke_u = 1'b1;
  logic                  ck = 1'b1;        // Clock enable for next op
  logic [31:0]           rd;
  logic                  rv;
  logic [2:0]            pwr;
  logic                  busy;             // Burst running
  logic [31:0]           mem [4][8];       // Expected storage
  logic [11:0]           rows [4];
  int                    err_total = 0;
  int                    compares = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  sdpci_if link ();
  sdpci_device u_sdpci_device (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pins(link),
    .pwr_state_out(pwr), .burst_active_out(busy));
  sdpci_host u_sdpci_host (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pins(link),
    .user_cmd_valid_in(cv), .user_cmd_in(cmd), .user_bank_in(bk), .user_addr_in(ad),
    .user_mask_in(mk), .user_wdata_valid_in(wv), .user_wdata_in(wd), .user_cke_in(cke_u),
    .user_rdata_out(rd), .user_rdata_valid_out(rv));
  sdpci_link_monitor u_sdpci_link_monitor (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .dqm(link.dqm),
    .host_dq_oe(link.host_dq_oe), .dev_dq(link.dev_dq), .dev_dq_oe(link.dev_dq_oe), .dq(link.dq));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] xm(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction : xm
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One user cycle, launched just after the edge
  task automatic op(input sdpci_pkg::sdpci_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                    input logic [3:0] m, input logic v, input logic [31:0] d);
    @(posedge sys_clk_in);
    cmd <= c;
    cv <= (c != sdpci_pkg::UC_DESEL) || 1'($urandom); // Idle cycles mix deselect and no-op
    bk <= b;
    ad <= a;
    mk <= m;
    wv <= v;
    wd <= d;
    cke_u <= ck;
  endtask : op
  task automatic idle(input int n);
    repeat (n) op(sdpci_pkg::UC_DESEL, 2'h0, 12'h000, 4'h0, 1'b0, 32'h0);
  endtask : idle
  task automatic act_all;
    for (int b = 0; b < 4; b++) begin
      op(sdpci_pkg::UC_ACT, 2'(b), rows[b], 4'h0, 1'b0, 32'h0);
    end
  endtask : act_all
  // Burst of four; masked lanes keep old bytes
  task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic ap);
    logic [31:0] d;
    logic [3:0]  m;
    logic [2:0]  ix;
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      m = 4'($urandom);
      ix = {c[2], 2'(c[1:0] + i)};
      mem[b][ix] = (mem[b][ix] & xm(m)) | (d & ~xm(m));
      op(i == 0 ? sdpci_pkg::UC_WRITE : sdpci_pkg::UC_DESEL, b, {1'b0, ap, 2'h0, c}, m, 1'b1, d);
    end
    idle(1);
  endtask : wr
  // Read mask given with the command hits the second beat
  task automatic rdb(input logic [1:0] b, input logic [7:0] c, input logic [3:0] rm);
    logic [2:0] ix;
    op(sdpci_pkg::UC_READ, b, {4'h0, c}, rm, 1'b0, 32'h0);
    idle(1);
    // Outputs looked at mid-cycle, clear of the edge that moves them
    for (int n = 0; n < 12 && rv !== 1'b1; n++) @(negedge sys_clk_in);
    for (int i = 0; i < 4; i++) begin
      ix = {c[2], 2'(c[1:0] + i)};
      chk("rvalid", {31'h0, rv}, 32'h1);
      chk("rdata", rd, mem[b][ix] & ~xm(i == 1 ? rm : 4'h0));
      @(negedge sys_clk_in);
    end
  endtask : rdb
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [1:0] b;
    logic [7:0] c;
    for (int i = 0; i < 32; i++) mem[i / 8][i % 8] = 32'h0;
    void'($urandom(57975));
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    idle(2);
    op(sdpci_pkg::UC_LOAD, 2'h0, 12'h022, 4'h0, 1'b0, 32'h0);
    for (int i = 0; i < 4; i++) rows[i] = 12'($urandom);
    act_all;
    for (int i = 0; i < 24; i++) begin
      b = 2'($urandom);
      c = (i == 0) ? 8'hFF : (i == 1) ? 8'h03 : 8'($urandom);
      wr(b, c, 1'($urandom));
      rdb(b, c, 4'($urandom));
    end
    $display("test traffic done");
    op(sdpci_pkg::UC_PRE, 2'h0, 12'h400, 4'h0, 1'b0, 32'h0);
    ck = 1'b0;
    idle(4);
    op(sdpci_pkg::UC_WRITE, 2'h0, 12'h0FF, 4'h0, 1'b1, 32'hA5A55A5A);
    chk("pwr", {29'h0, pwr}, {29'h0, sdpci_pkg::PWR_PRE_PD});
    ck = 1'b1;
    idle(6);
    act_all;
    rdb(2'h0, 8'hFF, 4'h0);
    $display("test power down done");
    op(sdpci_pkg::UC_READ, 2'h1, 12'h000, 4'h1, 1'b0, 32'h0);
    ck = 1'b0;
    idle(3);
    chk("busy", {31'h0, busy}, 32'h1);
    ck = 1'b1;
    idle(12);
    chk("pwr", {29'h0, pwr}, {29'h0, sdpci_pkg::PWR_RUN});
    chk("busy", {31'h0, busy}, 32'h0);
    $display("test suspend done");
    ck = 1'b0;
    op(sdpci_pkg::UC_RFSH, 2'h0, 12'h000, 4'h0, 1'b0, 32'h0);
    idle(3);
    chk("pwr", {29'h0, pwr}, {29'h0, sdpci_pkg::PWR_SELF});
    $display("test self refresh done");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    err_total++;
    complete_run;
  end
endmodule : sdram_pin_command_interface_tb
